// File: pkg/fec_pkg.sv
// package: constants, types and decode helpers for the flash command block
package fec_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_PPROT = 8'h08;
  localparam logic [7:0] OFS_EPROT = 8'h0C;
  localparam logic [7:0] OFS_MARGIN = 8'h10;
  localparam logic [7:0] OFS_SEC = 8'h14;
  localparam logic [7:0] OFS_RSV3 = 8'h18;
  localparam logic [7:0] OFS_RSV4 = 8'h1C;
  localparam logic [7:0] OFS_OPT = 8'h20;

  // command codes
  localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
  localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
  localparam logic [7:0] CMD_UNSECURE = 8'h0B;
  localparam logic [7:0] CMD_USER_MARGIN = 8'h0D;
  localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0E;
  localparam logic [7:0] CMD_VERIFY_SECT = 8'h10;
  localparam logic [7:0] CMD_PROGRAM_EE = 8'h11;
  localparam logic [7:0] CMD_SECTOR_EE = 8'h12;

  // field positions
  localparam int unsigned CMD_EE_TARGET = 8;
  localparam int unsigned STAT_CCF = 7;
  localparam int unsigned STAT_ACCERR = 5;
  localparam int unsigned STAT_PVIOL = 4;
  localparam int unsigned STAT_BUSY = 3;
  localparam int unsigned STAT_VERR = 1;
  localparam int unsigned PPROT_LOW_DIS = 0;
  localparam int unsigned PPROT_HIGH_DIS = 1;
  localparam int unsigned PPROT_OPEN = 2;
  localparam int unsigned EPROT_OPEN = 0;
  localparam int unsigned SEC_SECURED = 0;
  localparam int unsigned SEC_DEBUG_EN = 1;

  // reset values and fixed values
  localparam logic [2:0] PPROT_RESET = 3'h0;
  localparam logic EPROT_RESET = 1'b0;
  localparam logic [1:0] MARGIN_NORMAL = 2'h0;
  localparam logic [7:0] OPT_RESET = 8'h00;
  localparam logic [7:0] OPT_FAULT = 8'hFF;
  localparam logic [17:0] OPT_GLOBAL_ADDR = 18'h3FF0E;
  localparam logic [31:0] RSV_READ = 32'h0000_0000;

  // controller states
  typedef enum logic [2:0] {
    ST_RST_LOAD, ST_RST_VERIFY, ST_IDLE, ST_WAIT, ST_RUN
  } fec_state_e;

  // concurrency classes of a command
  typedef enum logic [2:0] {
    CL_NONE, CL_MASS, CL_VERIFY, CL_PROG, CL_SECTOR, CL_BAD
  } fec_class_e;

  // array operation handed to the array sequencer
  typedef struct packed {
    logic start;
    logic [7:0] code;
    logic ee_target;
  } fec_array_op_s;

  // nonvolatile byte read during the reset sequence
  typedef struct packed {
    logic req;
    logic [17:0] addr;
  } fec_nvm_rd_s;

  // classify a command code, used at launch and while running
  function automatic fec_class_e fec_class(input logic [7:0] code);
    case (code)
      CMD_ERASE_ALL, CMD_ERASE_BLOCK, CMD_UNSECURE: fec_class = CL_MASS;
      CMD_USER_MARGIN, CMD_FIELD_MARGIN: fec_class = CL_NONE;
      CMD_VERIFY_SECT: fec_class = CL_VERIFY;
      CMD_PROGRAM_EE: fec_class = CL_PROG;
      CMD_SECTOR_EE: fec_class = CL_SECTOR;
      default: fec_class = CL_BAD;
    endcase
  endfunction : fec_class

endpackage : fec_pkg

// File: src/fec_op_timer.sv
// down counter that times one array operation
`timescale 1ns/1ps
`default_nettype none
module fec_op_timer #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic run,
  // status
  output logic done
);

  logic [W-1:0] cnt_q; // cycles left
  logic [W-1:0] cnt_d; // next count

  // load wins over counting; a stalled run holds the count
  assign cnt_d = load ? load_val :
                 (run && cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
  assign done = (cnt_q == '0) && !load;

  // count register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : fec_op_timer
`default_nettype wire

// File: src/fec_flash_ctrl.sv
// flash command sequencer with security, option copy and concurrency arbiter
//
// Functional notes
// - reset verify finds both blank, unsecure device
// - both factory reserved registers read zero
// - option copy readable, writes ignored
// - option copy loaded from fixed address at reset
// - double fault on option read sets all ones
// - erase-all needs every protection bit open
// - erase-block of eeprom needs eeprom open bit
// - unsecure command erases, verifies, releases security
// - user margin set; field margin special only
// - erase verify checks eeprom words blank
// - program one to four eeprom words
// - sector erase clears one eeprom sector
// - only approved pflash/eeprom pairs run together
// - pflash reads take priority over eeprom writes
// - nonnormal margin makes eeprom reads margin reads
// - erase-all and erase-block count as mass erase
// - clearing complete flag launches; set when done
// - unsecure verify failure sets verify error only
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fec_flash_ctrl
  import fec_pkg::*;
#(
  parameter int unsigned TW = 16,
  parameter logic [TW-1:0] ERASE_CYCLES = 16'h0100,
  parameter logic [TW-1:0] PROG_CYCLES = 16'h0020,
  parameter logic [TW-1:0] VERIFY_CYCLES = 16'h0010
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode and array state
  input wire logic special_mode,
  input wire logic pflash_blank,
  input wire logic eeprom_blank,
  // reset-time nonvolatile read
  output fec_nvm_rd_s nvm_rd,
  input wire logic nvm_rd_valid,
  input wire logic [7:0] nvm_rd_data,
  input wire logic nvm_rd_dbl_fault,
  // array sequencer
  output fec_array_op_s array_op,
  // read arbitration
  input wire logic pflash_read_req,
  output logic pflash_read_grant,
  input wire logic eeprom_read_req,
  output logic eeprom_read_grant,
  output logic eeprom_margin_read,
  // security
  output logic secured,
  output logic debug_all_enable
);

  fec_state_e state_q, state_d; // sequencer state
  logic [8:0] cmd_q; // command code plus eeprom target bit
  logic ccf_q; // command complete flag
  logic accerr_q, pviol_q, verr_q; // sticky error flags
  logic [2:0] pprot_q; // pflash protection disables/open
  logic eprot_q; // eeprom protect open
  logic [1:0] margin_req_q; // level requested by software
  logic [1:0] margin_q; // active eeprom margin level
  logic [7:0] opt_q; // nonvolatile option copy
  logic secured_q; // device security state
  logic [31:0] prdata_q; // registered read data
  fec_array_op_s op_q; // start pulse to array

  // bus decode
  wire setup_ph = psel && !penable;
  wire access_ph = psel && penable;
  wire wr_en = access_ph && pwrite;
  wire hit_cmd = paddr == OFS_CMD;
  wire hit_stat = paddr == OFS_STAT;
  wire hit_pprot = paddr == OFS_PPROT;
  wire hit_eprot = paddr == OFS_EPROT;
  wire hit_margin = paddr == OFS_MARGIN;
  wire hit_sec = paddr == OFS_SEC;
  wire hit_rsv = (paddr == OFS_RSV3) || (paddr == OFS_RSV4);
  wire hit_opt = paddr == OFS_OPT;
  wire mapped = hit_cmd || hit_stat || hit_pprot || hit_eprot ||
                hit_margin || hit_sec || hit_rsv || hit_opt;

  // zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access_ph && !mapped;
  assign prdata = prdata_q;

  // launch: write one to the complete flag while idle and complete
  wire idle = state_q == ST_IDLE;
  wire launch = wr_en && hit_stat && pwdata[STAT_CCF] && ccf_q && idle;
  wire [7:0] code = cmd_q[7:0];
  wire ee_tgt = cmd_q[CMD_EE_TARGET];
  fec_class_e cls;
  assign cls = fec_class(code);
  wire pprot_open = &pprot_q;

  // launch checks
  wire bad_code = cls == CL_BAD;
  wire field_refused = (code == CMD_FIELD_MARGIN) && !special_mode;
  wire erase_all_locked = (code == CMD_ERASE_ALL) &&
                          !(pprot_open && eprot_q);
  wire block_locked = (code == CMD_ERASE_BLOCK) &&
                      (ee_tgt ? !eprot_q : !pprot_open);
  wire l_acc = launch && (bad_code || field_refused);
  wire l_pv = launch && !l_acc && (erase_all_locked || block_locked);
  wire l_margin = launch && !l_acc && (cls == CL_NONE);
  wire l_go = launch && !l_acc && !l_pv && (cls != CL_NONE);

  // pflash reads may only run beside eeprom program or sector erase
  wire run_or_wait = (state_q == ST_RUN) || (state_q == ST_WAIT);
  wire cls_read_ok = (cls == CL_PROG) || (cls == CL_SECTOR);
  wire cmd_blocks_read = run_or_wait && !cls_read_ok;
  wire margin_active = margin_q != MARGIN_NORMAL;

  // read arbitration; pflash reads come first unless a margin level is active
  assign pflash_read_grant = pflash_read_req && !cmd_blocks_read;
  assign eeprom_margin_read = margin_active;
  assign eeprom_read_grant = eeprom_read_req && idle &&
                             (!pflash_read_req || margin_active);

  // conflicting launch waits for the pflash read to finish
  wire conflict = pflash_read_req && !cls_read_ok;

  // operation timing
  logic [TW-1:0] op_len;
  assign op_len = (cls == CL_MASS) ? ERASE_CYCLES :
                  (cls == CL_VERIFY) ? VERIFY_CYCLES : PROG_CYCLES;
  wire start_run = (l_go && !conflict) ||
                   ((state_q == ST_WAIT) && !conflict);
  // program and sector erase pause while a pflash read is served
  wire timer_run = (state_q == ST_RUN) &&
                   !(cls_read_ok && pflash_read_req);
  logic op_done;
  wire run_end = (state_q == ST_RUN) && op_done;
  // one shared timer; its length is picked at load time
  fec_op_timer #(.W(TW)) u_timer (
    .pclk(pclk), .presetn(presetn),
    .load(start_run), .load_val(op_len),
    .run(timer_run), .done(op_done)
  );
  // completion checks
  wire both_blank = pflash_blank && eeprom_blank;
  wire unsec_pass = run_end && code == CMD_UNSECURE && both_blank;
  wire unsec_fail = run_end && code == CMD_UNSECURE && !both_blank;
  wire verify_fail = run_end && code == CMD_VERIFY_SECT && !eeprom_blank;
  wire rst_unsec = (state_q == ST_RST_VERIFY) && both_blank;

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      // wait for the option byte, then one verify cycle
      ST_RST_LOAD: state_d = nvm_rd_valid ? ST_RST_VERIFY : ST_RST_LOAD;
      ST_RST_VERIFY: state_d = ST_IDLE;
      ST_IDLE: begin
        if (l_go) begin
          state_d = conflict ? ST_WAIT : ST_RUN;
        end
      end
      // held launch starts once the pflash read is gone
      ST_WAIT: state_d = conflict ? ST_WAIT : ST_RUN;
      ST_RUN: state_d = op_done ? ST_IDLE : ST_RUN;
      default: state_d = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RST_LOAD;
    end else begin
      state_q <= state_d;
    end
  end

  // option copy loaded once during the reset sequence only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_q <= OPT_RESET;
    end else if (state_q == ST_RST_LOAD && nvm_rd_valid) begin
      opt_q <= nvm_rd_dbl_fault ? OPT_FAULT : nvm_rd_data;
    end
  end

  assign nvm_rd.req = state_q == ST_RST_LOAD;
  assign nvm_rd.addr = OPT_GLOBAL_ADDR;
  // complete flag: low from launch until the operation ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccf_q <= 1'b0;
    end else if (state_q == ST_RST_VERIFY || run_end) begin
      ccf_q <= 1'b1;
    end else if (l_go) begin
      ccf_q <= 1'b0;
    end
  end

  // error flags: write one clears, a new error in the same cycle wins
  wire clr_stat = wr_en && hit_stat;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accerr_q <= 1'b0;
      pviol_q <= 1'b0;
      verr_q <= 1'b0;
    end else begin
      accerr_q <= l_acc ||
                  (accerr_q && !(clr_stat && pwdata[STAT_ACCERR]));
      pviol_q <= l_pv ||
                 (pviol_q && !(clr_stat && pwdata[STAT_PVIOL]));
      verr_q <= unsec_fail || verify_fail ||
                (verr_q && !(clr_stat && pwdata[STAT_VERR]));
    end
  end

  // security: released by blank check at reset or unsecure command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secured_q <= 1'b1;
    end else if (rst_unsec || unsec_pass) begin
      secured_q <= 1'b0;
    end
  end

  assign secured = secured_q;
  assign debug_all_enable = !secured_q;

  // software-written control; command and protection frozen while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= 9'h000;
      pprot_q <= PPROT_RESET;
      eprot_q <= EPROT_RESET;
      margin_req_q <= MARGIN_NORMAL;
    end else if (wr_en && idle) begin
      cmd_q <= hit_cmd ? pwdata[8:0] : cmd_q;
      pprot_q <= hit_pprot ? pwdata[2:0] : pprot_q;
      eprot_q <= hit_eprot ? pwdata[EPROT_OPEN] : eprot_q;
      margin_req_q <= hit_margin ? pwdata[1:0] : margin_req_q;
    end
  end

  // margin commands take effect at once, no array time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      margin_q <= MARGIN_NORMAL;
    end else if (l_margin) begin
      margin_q <= margin_req_q;
    end
  end

  // array start pulse; mass erase kinds stay in one class
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= '0;
    end else begin
      op_q.start <= start_run;
      op_q.code <= code;
      op_q.ee_target <= ee_tgt;
    end
  end

  assign array_op = op_q;
  // read mux; reserved and unmapped words read zero
  logic [31:0] rd_mux;
  assign rd_mux =
    hit_cmd ? {23'h0, cmd_q} :
    hit_stat ? {24'h0, ccf_q, 1'b0, accerr_q, pviol_q,
                !ccf_q, 1'b0, verr_q, 1'b0} :
    hit_pprot ? {29'h0, pprot_q} :
    hit_eprot ? {31'h0, eprot_q} :
    hit_margin ? {26'h0, margin_q, 2'h0, margin_req_q} :
    hit_sec ? {30'h0, !secured_q, secured_q} :
    hit_opt ? {24'h0, opt_q} : RSV_READ;

  // read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rsv_zero;
    setup_ph && !pwrite && hit_rsv |=> prdata == 32'h0000_0000;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved register read not zero");

  property p_opt_ro;
    wr_en && hit_opt && idle |=> $stable(opt_q);
  endproperty
  a_opt_ro: assert property (p_opt_ro)
    else $error("option copy changed by a write");

  property p_opt_load;
    state_q == ST_RST_LOAD && nvm_rd_valid && !nvm_rd_dbl_fault
      |=> opt_q == $past(nvm_rd_data);
  endproperty
  a_opt_load: assert property (p_opt_load)
    else $error("option copy not loaded");

  property p_opt_fault;
    state_q == ST_RST_LOAD && nvm_rd_valid && nvm_rd_dbl_fault
      |=> opt_q == 8'hFF ##1 opt_q == 8'hFF;
  endproperty
  a_opt_fault: assert property (p_opt_fault)
    else $error("double fault did not set option bits");

  property p_erase_all_lock;
    launch && code == CMD_ERASE_ALL && !(pprot_open && eprot_q)
      |=> pviol_q && ccf_q && state_q == ST_IDLE && !array_op.start;
  endproperty
  a_erase_all_lock: assert property (p_erase_all_lock)
    else $error("locked erase-all was started");

  property p_field_margin;
    launch && code == CMD_FIELD_MARGIN && !special_mode
      |=> accerr_q && $stable(margin_q);
  endproperty
  a_field_margin: assert property (p_field_margin)
    else $error("field margin accepted outside special mode");

  property p_mass_blocks_read;
    state_q == ST_RUN && cls == CL_MASS |-> !pflash_read_grant;
  endproperty
  a_mass_blocks_read: assert property (p_mass_blocks_read)
    else $error("pflash read granted during mass erase");

  property p_launch_ccf;
    l_go |=> !ccf_q ##1 !ccf_q;
  endproperty
  a_launch_ccf: assert property (p_launch_ccf)
    else $error("complete flag not cleared by launch");

  property p_unsec_fail;
    unsec_fail && secured_q |=> verr_q && secured_q && ccf_q;
  endproperty
  a_unsec_fail: assert property (p_unsec_fail)
    else $error("failed unsecure changed security");

  property p_rst_unsec;
    rst_unsec |=> !secured_q && debug_all_enable && ccf_q;
  endproperty
  a_rst_unsec: assert property (p_rst_unsec)
    else $error("blank device stayed secured");

endmodule : fec_flash_ctrl
`default_nettype wire

// File: testbench/fec_nvm_model.sv
// partner model: nonvolatile store answering the reset-time option read
`timescale 1ns/1ps
`default_nettype none
module fec_nvm_model
  import fec_pkg::*;
#(
  parameter int unsigned DELAY = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request from the block
  input wire fec_nvm_rd_s nvm_rd,
  // stored content chosen by the bench
  input wire logic [7:0] opt_val,
  input wire logic fault,
  // answer
  output logic nvm_rd_valid,
  output logic [7:0] nvm_rd_data,
  output logic nvm_rd_dbl_fault
);
  logic [3:0] wait_q; // cycles since request seen
  logic done_q; // one answer per request
  logic hit; // address points at the option byte
  // answer only at the fixed option address, else wrong data
  assign hit = (nvm_rd.addr == 18'h3FF0E);
  assign nvm_rd_valid = nvm_rd.req && !done_q && (wait_q == DELAY[3:0]);
  // bus lines not valid show inverse, never a stale copy
  assign nvm_rd_data = (nvm_rd_valid && hit) ? opt_val : ~opt_val;
  assign nvm_rd_dbl_fault = nvm_rd_valid ? fault : ~fault;
  // slow answer: count DELAY cycles of request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 4'h0;
      done_q <= 1'b0;
    end else if (!nvm_rd.req) begin
      wait_q <= 4'h0;
      done_q <= 1'b0;
    end else if (nvm_rd_valid) begin
      done_q <= 1'b1;
    end else if (!done_q) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : fec_nvm_model
`default_nettype wire

// File: testbench/flash_eeprom_command_security_tb_top.sv
// testbench: register access, commands, security and concurrency
`timescale 1ns/1ps
`default_nettype none
module flash_eeprom_command_security_tb_top
  import fec_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic special_mode = 1'b1, pflash_blank = 1'b0, eeprom_blank = 1'b0;
  fec_nvm_rd_s nvm_rd;
  logic nvm_rd_valid, nvm_rd_dbl_fault;
  logic [7:0] nvm_rd_data;
  logic [7:0] opt_val = 8'h5A;
  logic fault = 1'b0;
  fec_array_op_s array_op;
  logic pflash_read_req = 1'b0, eeprom_read_req = 1'b0;
  logic pflash_read_grant, eeprom_read_grant, eeprom_margin_read;
  logic secured, debug_all_enable;
  int error_cnt = 0;
  int total_checks = 0;
  logic [31:0] rd; // last read word
  logic err_seen; // pslverr at the last access edge
  int start_cnt = 0; // array start pulses counted
  int start_base = 0; // count when the last command was loaded
  wire start_seen = (start_cnt != start_base); // a start since then

  always #20 pclk = ~pclk;

  // short counts keep the run brief
  fec_flash_ctrl #(.TW(16), .ERASE_CYCLES(16'h0004),
    .PROG_CYCLES(16'h0004), .VERIFY_CYCLES(16'h0004)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .special_mode(special_mode),
    .pflash_blank(pflash_blank), .eeprom_blank(eeprom_blank),
    .nvm_rd(nvm_rd), .nvm_rd_valid(nvm_rd_valid),
    .nvm_rd_data(nvm_rd_data), .nvm_rd_dbl_fault(nvm_rd_dbl_fault),
    .array_op(array_op), .pflash_read_req(pflash_read_req),
    .pflash_read_grant(pflash_read_grant),
    .eeprom_read_req(eeprom_read_req),
    .eeprom_read_grant(eeprom_read_grant),
    .eeprom_margin_read(eeprom_margin_read), .secured(secured),
    .debug_all_enable(debug_all_enable));

  fec_nvm_model #(.DELAY(3)) u_nvm (
    .pclk(pclk), .presetn(presetn), .nvm_rd(nvm_rd), .opt_val(opt_val),
    .fault(fault), .nvm_rd_valid(nvm_rd_valid),
    .nvm_rd_data(nvm_rd_data), .nvm_rd_dbl_fault(nvm_rd_dbl_fault));

  // watch for the one-cycle start pulse
  always @(posedge pclk) begin
    if (array_op.start === 1'b1) start_cnt <= start_cnt + 1;
  end

  // verdict and end of run
  task automatic tally_and_finish;
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // compare one word
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check

  // one apb transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // poll status until the complete flag is back
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STAT, 32'h0);
      n++;
    end while (rd[STAT_CCF] !== 1'b1 && n < 300);
    check({31'h0, rd[STAT_CCF]}, 32'h1);
  endtask : wait_idle

  // load a command and launch it; the caller waits for completion
  task automatic run_cmd(input logic [31:0] cmd);
    start_base = start_cnt;
    apb(1'b1, OFS_CMD, cmd);
    apb(1'b1, OFS_STAT, 32'h80);
  endtask : run_cmd

  // reset with chosen option byte and array state; special_mode is left as the caller set it
  task automatic do_reset(input logic [7:0] o, input logic f,
                          input logic b);
    @(posedge pclk);
    presetn <= 1'b0;
    opt_val <= o;
    fault <= f;
    pflash_blank <= b;
    eeprom_blank <= b;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    wait_idle();
  endtask : do_reset

  // safety net against a hang
  initial begin
    #(40 * 30000);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    do_reset(8'h5A, 1'b0, 1'b0);
    check({30'h0, debug_all_enable, secured}, 32'h1);
    apb(1'b1, OFS_OPT, 32'hFF);
    apb(1'b0, OFS_OPT, 32'h0);
    check(rd, 32'h5A);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, (i != 0) ? OFS_RSV4 : OFS_RSV3, 32'hFFFF_FFFF);
      apb(1'b0, (i != 0) ? OFS_RSV4 : OFS_RSV3, 32'h0);
      check(rd, RSV_READ);
    end
    apb(1'b0, 8'h24, 32'h0);
    check({err_seen, rd[30:0]}, 32'h8000_0000);
    // erase-all refused while protection is closed
    run_cmd(32'h08);
    wait_idle();
    check(rd & 32'h90, 32'h90);
    apb(1'b1, OFS_STAT, 32'h10);
    apb(1'b1, OFS_PPROT, 32'h7);
    apb(1'b1, OFS_EPROT, 32'h1);
    // unsecure with arrays not blank leaves security alone
    run_cmd(32'h0B);
    wait_idle();
    check({rd[1], 30'h0, secured}, 32'h8000_0001);
    apb(1'b1, OFS_STAT, 32'h02);
    pflash_blank <= 1'b1;
    eeprom_blank <= 1'b1;
    run_cmd(32'h0B);
    wait_idle();
    check({30'h0, debug_all_enable, secured}, 32'h2);
    run_cmd(32'h08);
    wait_idle();
    check(rd & 32'hB2, 32'h80);
    // full eeprom block erase refused while eeprom is closed
    apb(1'b1, OFS_EPROT, 32'h0);
    run_cmd(32'h109);
    wait_idle();
    check(rd & 32'h90, 32'h90);
    apb(1'b1, OFS_STAT, 32'h10);
    apb(1'b1, OFS_EPROT, 32'h1);
    // mass erase held off while pflash is being read
    pflash_read_req <= 1'b1;
    run_cmd(32'h09);
    repeat (10) @(posedge pclk);
    check({start_seen, pflash_read_grant}, 32'h0);
    apb(1'b0, OFS_STAT, 32'h0);
    check(rd[STAT_BUSY], 32'h1);
    pflash_read_req <= 1'b0;
    repeat (2) @(posedge pclk);
    pflash_read_req <= 1'b1;
    @(posedge pclk);
    check({start_seen, pflash_read_grant}, 32'h2);
    pflash_read_req <= 1'b0;
    wait_idle();
    check(start_seen, 32'h1);
    // eeprom program runs beside pflash reads
    pflash_read_req <= 1'b1;
    run_cmd(32'h11);
    repeat (4) @(posedge pclk);
    check({start_seen, pflash_read_grant}, 32'h3);
    pflash_read_req <= 1'b0;
    wait_idle();
    check(rd & 32'hB2, 32'h80);
    run_cmd(32'h12);
    wait_idle();
    check({rd[7], start_seen}, 32'h3);
    eeprom_blank <= 1'b0;
    run_cmd(32'h10);
    wait_idle();
    check(rd & 32'h82, 32'h82);
    // field margin refused outside special mode
    special_mode <= 1'b0;
    run_cmd(32'h0E);
    wait_idle();
    check(rd & 32'hA0, 32'hA0);
    special_mode <= 1'b1;
    apb(1'b1, OFS_MARGIN, 32'h1);
    run_cmd(32'h0D);
    wait_idle();
    apb(1'b0, OFS_MARGIN, 32'h0);
    check(rd[5:4], 32'h1);
    pflash_read_req <= 1'b1;
    eeprom_read_req <= 1'b1;
    @(posedge pclk);
    @(posedge pclk);
    check({eeprom_margin_read, eeprom_read_grant}, 32'h3);
    pflash_read_req <= 1'b0;
    eeprom_read_req <= 1'b0;
    // fresh reset after erase: blank arrays, faulty option phrase
    do_reset(8'h5A, 1'b1, 1'b1);
    apb(1'b0, OFS_OPT, 32'h0);
    check(rd, {24'h0, OPT_FAULT});
    check({30'h0, debug_all_enable, secured}, 32'h2);
    apb(1'b0, OFS_SEC, 32'h0);
    check(rd[1:0], 32'h2);
    tally_and_finish();
  end
endmodule : flash_eeprom_command_security_tb_top
`default_nettype wire
